// file: hdl/uart_channel.sv
// one asynchronous serial channel with an axi4-lite register slave
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module uart_channel (
  // system
  input wire logic clock,
  input wire logic rst_b,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // serial line and modem
  input wire logic rxd,
  output logic txd,
  input wire logic ctsN,
  output logic rtsN,
  input wire logic ext_baud_clock_in,
  // interrupt
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0] rstPipe;
  logic resetN;
  uart_pkg::cfg_s cfg, next_cfg;
  logic [uart_pkg::PRESC_W-1:0] prescDiv, next_prescDiv, prescCnt, next_prescCnt;
  logic [uart_pkg::IRQ_W-1:0] irqMask, next_irqMask, irqStatus, next_irqStatus;
  logic awHave, next_awHave, wHave, next_wHave;
  logic [7:0] awAddrQ, next_awAddrQ;
  logic [31:0] wDataQ, next_wDataQ, rdataFor, merged;
  logic [3:0] wStrbQ, next_wStrbQ;
  logic next_bvalid, next_rvalid, next_irq, next_txd, extPrev;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic doWrite, doRead, tick, rxIn;
  logic [7:0] rxMem [4];
  logic [7:0] next_rxMem [4];
  logic [7:0] txMem [2];
  logic [7:0] next_txMem [2];
  logic [1:0] rxWr, next_rxWr, rxRd, next_rxRd;
  logic txWr, next_txWr, txRd, next_txRd;
  logic [2:0] rxCount, next_rxCount;
  logic [1:0] txCount, next_txCount;
  logic rxPush, rxPop, txPush, txStart, rxFull, txFull;
  logic txBusy, txDone, txBit, rxDone, rxParErr, rxFrameErr;
  logic [7:0] rxData;
  uart_pkg::ev_s events;
  uart_pkg::status_s status;

  // reset is released through two flops so every flop leaves reset on one edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) rstPipe <= 2'h0;
    else rstPipe <= {rstPipe[0], 1'b1};
  end
  assign resetN = rstPipe[1];

  ////////////////////////////////////////////////////////////////////////////////
  // baud timer: one tick per sixteenth of a bit, shared by both directions
  always_comb begin
    next_prescCnt = prescCnt + 16'h0001;
    if (cfg.extClock || prescCnt >= prescDiv) next_prescCnt = 16'h0000;
  end
  assign tick = cfg.extClock ? (ext_baud_clock_in && !extPrev)
                             : (prescCnt >= prescDiv);

  always_ff @(posedge clock or negedge resetN) begin
    if (!resetN) begin
      prescCnt <= 16'h0000;
      extPrev <= 1'b0;
    end else begin
      prescCnt <= next_prescCnt;
      extPrev <= ext_baud_clock_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receiver and transmitter share the tick and the format; in local loopback txBit feeds the receiver while txd is held high
  uart_rx rxUnit (
    .clock(clock),
    .resetN(resetN),
    .tick(tick),
    .cfg(cfg),
    .rxIn(rxIn),
    .done(rxDone),
    .data(rxData),
    .parityErr(rxParErr),
    .frameErr(rxFrameErr)
  );

  uart_tx txUnit (
    .clock(clock),
    .resetN(resetN),
    .tick(tick),
    .cfg(cfg),
    .start(txStart),
    .data(txMem[txRd]),
    .busy(txBusy),
    .done(txDone),
    .txBit(txBit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // line routing per mode; echo and remote loopback keep the cpu off the line
  always_comb begin
    unique case (cfg.mode)
      uart_pkg::MODE_LOCAL: begin
        rxIn = txBit;
        next_txd = 1'b1;
      end
      uart_pkg::MODE_ECHO: begin
        rxIn = rxd;
        next_txd = rxd;
      end
      uart_pkg::MODE_REMOTE: begin
        rxIn = 1'b1;
        next_txd = rxd;
      end
      default: begin
        rxIn = rxd;
        next_txd = txBit;
      end
    endcase
  end
  assign rtsN = !cfg.rtsOn;

  ////////////////////////////////////////////////////////////////////////////////
  // character buffers
  assign rxFull = rxCount == uart_pkg::RX_DEPTH;
  assign txFull = txCount == uart_pkg::TX_DEPTH;
  assign rxPush = rxDone && cfg.rxEnable && !rxFull;
  assign rxPop = doRead && araddr == uart_pkg::OFF_DATA && rxCount != 3'h0;
  assign txPush = doWrite && awAddrQ == uart_pkg::OFF_DATA && wStrbQ[0] && !txFull;
  // clear-to-send is checked only between characters, never mid-frame
  assign txStart = !txBusy && txCount != 2'h0 && cfg.txEnable && !ctsN &&
                   (cfg.mode == uart_pkg::MODE_NORMAL || cfg.mode == uart_pkg::MODE_LOCAL);

  always_comb begin
    next_rxMem = rxMem;
    next_txMem = txMem;
    next_rxWr = rxWr;
    next_rxRd = rxRd;
    next_txWr = txWr;
    next_txRd = txRd;
    if (rxPush) begin
      next_rxMem[rxWr] = rxData;
      next_rxWr = rxWr + 2'h1;
    end
    if (rxPop) next_rxRd = rxRd + 2'h1;
    if (txPush) begin
      next_txMem[txWr] = wDataQ[7:0];
      next_txWr = !txWr;
    end
    if (txStart) next_txRd = !txRd;
    next_rxCount = rxCount + 3'(rxPush) - 3'(rxPop);
    next_txCount = txCount + 2'(txPush) - 2'(txStart);
  end

  always_ff @(posedge clock or negedge resetN) begin
    if (!resetN) begin
      rxMem <= '{default: 8'h00};
      txMem <= '{default: 8'h00};
      rxWr <= 2'h0;
      rxRd <= 2'h0;
      txWr <= 1'b0;
      txRd <= 1'b0;
      rxCount <= 3'h0;
      txCount <= 2'h0;
    end else begin
      rxMem <= next_rxMem;
      txMem <= next_txMem;
      rxWr <= next_rxWr;
      rxRd <= next_rxRd;
      txWr <= next_txWr;
      txRd <= next_txRd;
      rxCount <= next_rxCount;
      txCount <= next_txCount;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // events and status
  always_comb begin
    events.rxReady = rxPush;
    events.txEmpty = txDone && txCount == 2'h0;
    events.overrun = rxDone && cfg.rxEnable && rxFull;
    events.parityErr = rxDone && cfg.rxEnable && rxParErr;
    events.frameErr = rxDone && cfg.rxEnable && rxFrameErr;
    status.ctsAsserted = !ctsN;
    status.txIdle = !txBusy && txCount == 2'h0;
    status.txLevel = txCount;
    status.rxLevel = rxCount;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave; address and data may arrive in either order
  assign awready = !awHave;
  assign wready = !wHave;
  assign arready = !rvalid;
  assign doWrite = awHave && wHave && !bvalid;
  assign doRead = arvalid && arready;

  always_comb begin
    case (araddr)
      uart_pkg::OFF_DATA: rdataFor = 32'(rxMem[rxRd]);
      uart_pkg::OFF_CONFIG: rdataFor = 32'(cfg);
      uart_pkg::OFF_PRESCALE: rdataFor = 32'(prescDiv);
      uart_pkg::OFF_STATUS: rdataFor = 32'(status);
      uart_pkg::OFF_IRQ_STATUS: rdataFor = 32'(irqStatus);
      uart_pkg::OFF_IRQ_MASK: rdataFor = 32'(irqMask);
      default: rdataFor = 32'h00000000;
    endcase
  end

  always_comb begin
    next_awHave = awHave;
    next_wHave = wHave;
    next_awAddrQ = awAddrQ;
    next_wDataQ = wDataQ;
    next_wStrbQ = wStrbQ;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !rready;
    next_rresp = rresp;
    next_rdata = rdata;
    next_cfg = cfg;
    next_prescDiv = prescDiv;
    next_irqMask = irqMask;
    next_irqStatus = irqStatus;
    merged = 32'h00000000;
    if (awvalid && awready) begin
      next_awHave = 1'b1;
      next_awAddrQ = awaddr;
    end
    if (wvalid && wready) begin
      next_wHave = 1'b1;
      next_wDataQ = wdata;
      next_wStrbQ = wstrb;
    end
    if (doWrite) begin
      next_awHave = 1'b0;
      next_wHave = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = uart_pkg::RESP_OKAY;
      if (!uart_pkg::isMapped(awAddrQ) || (awAddrQ == uart_pkg::OFF_DATA && txFull)) begin
        next_bresp = uart_pkg::RESP_SLVERR;
      end
      unique case (awAddrQ)
        uart_pkg::OFF_CONFIG: begin
          merged = uart_pkg::mergeStrb(32'(cfg), wDataQ, wStrbQ);
          next_cfg = uart_pkg::cfg_s'(merged[uart_pkg::CFG_W-1:0]);
        end
        uart_pkg::OFF_PRESCALE: begin
          merged = uart_pkg::mergeStrb(32'(prescDiv), wDataQ, wStrbQ);
          next_prescDiv = merged[uart_pkg::PRESC_W-1:0];
        end
        uart_pkg::OFF_IRQ_MASK: begin
          merged = uart_pkg::mergeStrb(32'(irqMask), wDataQ, wStrbQ);
          next_irqMask = merged[uart_pkg::IRQ_W-1:0];
        end
        uart_pkg::OFF_IRQ_STATUS: begin
          if (wStrbQ[0]) next_irqStatus = irqStatus & ~wDataQ[uart_pkg::IRQ_W-1:0];
        end
        default: merged = 32'h00000000;
      endcase
    end
    // a new event beats a clear written in the same cycle
    next_irqStatus = next_irqStatus | events;
    if (doRead) begin
      next_rvalid = 1'b1;
      next_rdata = rdataFor;
      next_rresp = uart_pkg::isMapped(araddr) ? uart_pkg::RESP_OKAY : uart_pkg::RESP_SLVERR;
    end
    next_irq = |(irqStatus & irqMask);
  end

  always_ff @(posedge clock or negedge resetN) begin
    if (!resetN) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
      bvalid <= 1'b0;
      bresp <= uart_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= uart_pkg::RESP_OKAY;
      rdata <= 32'h00000000;
      cfg <= uart_pkg::CFG_RESET;
      prescDiv <= uart_pkg::PRESC_RESET;
      irqMask <= uart_pkg::IRQ_MASK_RESET;
      irqStatus <= 5'h00;
      irq <= 1'b0;
      txd <= 1'b1;
    end else begin
      awHave <= next_awHave;
      wHave <= next_wHave;
      awAddrQ <= next_awAddrQ;
      wDataQ <= next_wDataQ;
      wStrbQ <= next_wStrbQ;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      cfg <= next_cfg;
      prescDiv <= next_prescDiv;
      irqMask <= next_irqMask;
      irqStatus <= next_irqStatus;
      irq <= next_irq;
      txd <= next_txd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_ext_tick: assert property (@(posedge clock) disable iff (!resetN)
    (cfg.extClock && !ext_baud_clock_in) |-> ##1 (tick == ext_baud_clock_in))
    else $error("external baud edge did not make exactly one tick");
  a_presc_gap: assert property (@(posedge clock) disable iff (!resetN)
    (!cfg.extClock && tick && prescDiv != 16'h0000 && $stable(prescDiv)) |=> !tick)
    else $error("prescaler ticked on consecutive cycles");
  a_rx_level: assert property (@(posedge clock) disable iff (!resetN)
    (rxPush && !rxPop) |=> rxCount == $past(rxCount) + 3'h1)
    else $error("received character not buffered");
  a_tx_level: assert property (@(posedge clock) disable iff (!resetN)
    txCount <= uart_pkg::TX_DEPTH && rxCount <= uart_pkg::RX_DEPTH)
    else $error("buffer level beyond depth");
  a_overrun_drop: assert property (@(posedge clock) disable iff (!resetN)
    (rxDone && cfg.rxEnable && rxFull && !rxPop) |=> rxFull && irqStatus[2])
    else $error("overrun not flagged or character not dropped");
  a_cts_gate: assert property (@(posedge clock) disable iff (!resetN)
    txStart |-> !ctsN ##1 txBusy)
    else $error("transmitter started without clear-to-send");
  a_echo_path: assert property (@(posedge clock) disable iff (!resetN)
    (cfg.mode == uart_pkg::MODE_ECHO) |=> txd == $past(rxd))
    else $error("echo mode did not mirror the receive line");
  a_local_quiet: assert property (@(posedge clock) disable iff (!resetN)
    (cfg.mode == uart_pkg::MODE_LOCAL) [*2] |-> txd)
    else $error("line not idle during local loopback");
  a_irq_level: assert property (@(posedge clock) disable iff (!resetN)
    (events.parityErr && irqMask[3]) |=> ##1 irq)
    else $error("unmasked parity error did not raise interrupt");
endmodule // uart_channel

// file: hdl/uart_pkg.sv
// constants, types and helpers shared by the serial channel files
package uart_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_PRESCALE = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  localparam int CFG_W = 15;
  localparam int IRQ_W = 5;
  localparam int PRESC_W = 16;
  localparam logic [CFG_W-1:0] CFG_RESET = 15'h30F3;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 16'h0081;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;

  // buffer depths, typed at the level counter widths
  localparam logic [2:0] RX_DEPTH = 3'h4;
  localparam logic [1:0] TX_DEPTH = 2'h2;

  // sixteen ticks per bit; start is checked at its middle
  localparam logic [4:0] BIT_LAST = 5'h0F;
  localparam logic [4:0] HALF_BIT = 5'h07;
  localparam logic [2:0] BASE_LAST = 3'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00, MODE_ECHO = 2'b01, MODE_LOCAL = 2'b10, MODE_REMOTE = 2'b11
  } mode_e;
  typedef enum logic [1:0] {
    PAR_NONE = 2'b00, PAR_EVEN = 2'b01, PAR_ODD = 2'b10, PAR_NONE_ALT = 2'b11
  } parity_e;
  typedef enum logic [2:0] {
    SER_IDLE = 3'b000, SER_START = 3'b001, SER_DATA = 3'b010, SER_PAR = 3'b011,
    SER_STOP = 3'b100
  } serial_e;

  // configuration register layout, low bit last
  typedef struct packed {
    logic rtsOn;
    logic txEnable;
    logic rxEnable;
    logic extClock;
    mode_e mode;
    logic [4:0] stopLen;
    parity_e parity;
    logic [1:0] charLen;
  } cfg_s;

  typedef struct packed {
    logic frameErr;
    logic parityErr;
    logic overrun;
    logic txEmpty;
    logic rxReady;
  } ev_s;

  typedef struct packed {
    logic ctsAsserted;
    logic txIdle;
    logic [1:0] txLevel;
    logic [2:0] rxLevel;
  } status_s;

  function automatic logic [2:0] lastBit(logic [1:0] len);
    return 3'(BASE_LAST + 3'(len));
  endfunction

  function automatic logic hasParity(parity_e p);
    return (p == PAR_EVEN) || (p == PAR_ODD);
  endfunction

  function automatic logic parityOf(logic [7:0] d, logic [1:0] len, parity_e p);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - len);
    return (^(d & m)) ^ (p == PAR_ODD);
  endfunction

  function automatic logic isMapped(logic [7:0] a);
    return a == OFF_DATA || a == OFF_CONFIG || a == OFF_PRESCALE || a == OFF_STATUS ||
           a == OFF_IRQ_STATUS || a == OFF_IRQ_MASK;
  endfunction

  function automatic logic [31:0] mergeStrb(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i+:8] = n[8*i+:8];
    end
    return r;
  endfunction
endpackage

// file: hdl/uart_rx.sv
// serial receiver: sixteen-times sampling, parity and framing checks
`timescale 1ns/1ps
module uart_rx (
  // clock and reset
  input wire logic clock,
  input wire logic resetN,
  // timing and format
  input wire logic tick,
  input wire uart_pkg::cfg_s cfg,
  // serial in
  input wire logic rxIn,
  // character out
  output logic done,
  output logic [7:0] data,
  output logic parityErr,
  output logic frameErr
);
  uart_pkg::serial_e state, next_state;
  logic [4:0] ticks, next_ticks;
  logic [2:0] bitIdx, next_bitIdx;
  logic [7:0] next_data;
  logic next_done, next_parityErr, next_frameErr;
  logic bitEnd;

  assign bitEnd = tick && ticks == uart_pkg::BIT_LAST;

  always_comb begin
    next_state = state;
    next_ticks = ticks;
    next_bitIdx = bitIdx;
    next_data = data;
    next_done = 1'b0;
    next_parityErr = parityErr;
    next_frameErr = frameErr;
    if (tick) next_ticks = ticks + 5'h01;
    unique case (state)
      uart_pkg::SER_IDLE: begin
        next_ticks = 5'h00;
        if (tick && !rxIn) begin
          next_state = uart_pkg::SER_START;
          next_data = 8'h00;
          next_parityErr = 1'b0;
        end
      end
      // a start that is gone by mid-bit is taken as a glitch
      uart_pkg::SER_START: if (tick && ticks == uart_pkg::HALF_BIT) begin
        next_ticks = 5'h00;
        next_bitIdx = 3'h0;
        next_state = rxIn ? uart_pkg::SER_IDLE : uart_pkg::SER_DATA;
      end
      uart_pkg::SER_DATA: if (bitEnd) begin
        next_ticks = 5'h00;
        next_data[bitIdx] = rxIn;
        if (bitIdx == uart_pkg::lastBit(cfg.charLen)) begin
          next_state = uart_pkg::hasParity(cfg.parity) ? uart_pkg::SER_PAR : uart_pkg::SER_STOP;
        end else begin
          next_bitIdx = bitIdx + 3'h1;
        end
      end
      uart_pkg::SER_PAR: if (bitEnd) begin
        next_ticks = 5'h00;
        next_state = uart_pkg::SER_STOP;
        next_parityErr = rxIn != uart_pkg::parityOf(data, cfg.charLen, cfg.parity);
      end
      uart_pkg::SER_STOP: if (bitEnd) begin
        next_state = uart_pkg::SER_IDLE;
        next_done = 1'b1;
        next_frameErr = !rxIn;
      end
      default: next_state = uart_pkg::SER_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetN) begin
    if (!resetN) begin
      state <= uart_pkg::SER_IDLE;
      ticks <= 5'h00;
      bitIdx <= 3'h0;
      data <= 8'h00;
      done <= 1'b0;
      parityErr <= 1'b0;
      frameErr <= 1'b0;
    end else begin
      state <= next_state;
      ticks <= next_ticks;
      bitIdx <= next_bitIdx;
      data <= next_data;
      done <= next_done;
      parityErr <= next_parityErr;
      frameErr <= next_frameErr;
    end
  end

  a_no_parity: assert property (@(posedge clock) disable iff (!resetN)
    (state == uart_pkg::SER_IDLE && !rxIn && tick) |=> !parityErr)
    else $error("parity error not cleared at start of character");
endmodule // uart_rx

// file: hdl/uart_tx.sv
// serial transmitter: start, 5 to 8 data bits, optional parity, timed stop
`timescale 1ns/1ps
module uart_tx (
  // clock and reset
  input wire logic clock,
  input wire logic resetN,
  // timing and format
  input wire logic tick,
  input wire uart_pkg::cfg_s cfg,
  // character in
  input wire logic start,
  input wire logic [7:0] data,
  // serial out
  output logic busy,
  output logic done,
  output logic txBit
);
  uart_pkg::serial_e state, next_state;
  logic [4:0] ticks, next_ticks;
  logic [2:0] bitIdx, next_bitIdx;
  logic [7:0] shift, next_shift;
  logic next_done;
  logic bitEnd;

  assign bitEnd = tick && ticks == uart_pkg::BIT_LAST;
  assign busy = state != uart_pkg::SER_IDLE;

  always_comb begin
    next_state = state;
    next_ticks = ticks;
    next_bitIdx = bitIdx;
    next_shift = shift;
    next_done = 1'b0;
    if (tick) next_ticks = ticks + 5'h01;
    unique case (state)
      uart_pkg::SER_IDLE: begin
        next_ticks = 5'h00;
        if (start) begin
          next_state = uart_pkg::SER_START;
          next_shift = data;
        end
      end
      uart_pkg::SER_START: if (bitEnd) begin
        next_state = uart_pkg::SER_DATA;
        next_ticks = 5'h00;
        next_bitIdx = 3'h0;
      end
      uart_pkg::SER_DATA: if (bitEnd) begin
        next_ticks = 5'h00;
        if (bitIdx == uart_pkg::lastBit(cfg.charLen)) begin
          next_state = uart_pkg::hasParity(cfg.parity) ? uart_pkg::SER_PAR : uart_pkg::SER_STOP;
        end else begin
          next_bitIdx = bitIdx + 3'h1;
        end
      end
      uart_pkg::SER_PAR: if (bitEnd) begin
        next_state = uart_pkg::SER_STOP;
        next_ticks = 5'h00;
      end
      // stop lasts stopLen+1 sixteenths, one to thirty-two
      uart_pkg::SER_STOP: if (tick && ticks == cfg.stopLen) begin
        next_state = uart_pkg::SER_IDLE;
        next_done = 1'b1;
      end
      default: next_state = uart_pkg::SER_IDLE;
    endcase
  end

  always_comb begin
    unique case (state)
      uart_pkg::SER_START: txBit = 1'b0;
      uart_pkg::SER_DATA: txBit = shift[bitIdx];
      uart_pkg::SER_PAR: txBit = uart_pkg::parityOf(shift, cfg.charLen, cfg.parity);
      default: txBit = 1'b1;
    endcase
  end

  always_ff @(posedge clock or negedge resetN) begin
    if (!resetN) begin
      state <= uart_pkg::SER_IDLE;
      ticks <= 5'h00;
      bitIdx <= 3'h0;
      shift <= 8'h00;
      done <= 1'b0;
    end else begin
      state <= next_state;
      ticks <= next_ticks;
      bitIdx <= next_bitIdx;
      shift <= next_shift;
      done <= next_done;
    end
  end

  a_stop_length: assert property (@(posedge clock) disable iff (!resetN)
    (state == uart_pkg::SER_STOP && tick && ticks == cfg.stopLen) |=> done && !busy)
    else $error("stop interval did not end at programmed length");
endmodule // uart_tx

// file: test/serial_peer.sv
// far serial device: sends characters on rxd, captures txd
`timescale 1ns/1ps
module serial_peer (
  // line
  input wire logic clock,
  input wire logic txd,
  output logic rxd,
  output logic ctsN
);
  int nb = 8;
  int pe = 0;
  logic [8:0] got[$];
  logic [8:0] sh;
  initial {rxd, ctsN} = 2'h2;
  // 16 clocks a bit with prescale 0; bit 8 carries parity
  task automatic send(input logic [8:0] c);
    for (int i = -1; i <= nb + pe; i++) begin
      rxd <= i < 0 ? 1'b0 : i == nb + pe ? 1'b1 : c[i < nb ? i : 8];
      repeat (16) @(posedge clock);
    end
  endtask
  always begin
    @(negedge txd);
    sh = '0;
    repeat (8) @(posedge clock);
    for (int i = 0; i < nb + pe; i++) begin
      repeat (16) @(posedge clock);
      sh[i < nb ? i : 8] = txd;
    end
    repeat (16) @(posedge clock);
    got.push_back(sh);
  end
endmodule // serial_peer

// file: test/tb_top.sv
// bench for the serial channel: bus master, reference queue, scenarios
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, txd, rtsN;
  logic irq, rxd, ctsN, extClk = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ch;
  logic [31:0] wdata = 32'h0, rdata, v, seed = 32'h40;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, r, pr;
  logic [7:0] ex[$];
  int err_count = 0;
  int checks = 0;
  uart_channel i_uart_channel (.clock, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .rxd, .txd, .ctsN, .rtsN, .ext_baud_clock_in(extClk), .irq);
  serial_peer i_serial_peer (.clock, .txd, .rxd, .ctsN);
  initial forever #25 clock = ~clock;
  // external baud source runs free; ignored until selected
  always @(posedge clock) extClk <= ~extClk;
  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tmo();
    err_count++;
    wrap_up();
  endtask
  // each channel dropped at the edge that takes it; a spare edge keeps strobes apart
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    logic b = 1'b0;
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    for (int n = 0; n < 99 && !b; n++) begin
      @(negedge clock);
      {aw, w, b, r} = {awvalid & awready, wvalid & wready, bvalid, bresp};
      @(posedge clock);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    if (!b) tmo();
    bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [33:0] e);
    logic ar;
    logic b = 1'b0;
    {araddr, arvalid, rready} <= {a, 2'h3};
    for (int n = 0; n < 99 && !b; n++) begin
      @(negedge clock);
      {ar, b, v, pr} = {arvalid & arready, rvalid, rdata, rresp};
      @(posedge clock);
      if (ar) arvalid <= 1'b0;
    end
    if (!b) tmo();
    rready <= 1'b0;
    @(posedge clock);
    chk({pr, v}, e);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    rdc(uart_pkg::OFF_CONFIG, 34'(uart_pkg::CFG_RESET));
    rdc(uart_pkg::OFF_PRESCALE, 34'(uart_pkg::PRESC_RESET));
    rdc(uart_pkg::OFF_IRQ_MASK, 34'h0);
    rdc(8'h20, {uart_pkg::RESP_SLVERR, 32'h0});
    wr(uart_pkg::OFF_PRESCALE, 32'h0);
    wr(uart_pkg::OFF_IRQ_MASK, 32'h0C);
    // every length; parity even at 6 bits, odd at 8
    for (int l = 0; l < 4; l++) begin
      i_serial_peer.nb = 5 + l;
      i_serial_peer.pe = l % 2;
      wr(uart_pkg::OFF_CONFIG, 32'({uart_pkg::CFG_RESET[14:4], l == 3, l == 1, 2'(l)}));
      ch = 8'(xs()) & (8'hFF >> (3 - l));
      wr(uart_pkg::OFF_DATA, 32'(ch));
      chk(34'(r), 34'h0);
      for (int n = 0; n < 400 && i_serial_peer.got.size() == 0; n++) @(posedge clock);
      if (i_serial_peer.got.size() == 0) tmo();
      chk(34'(i_serial_peer.got.pop_front()), {25'h0, l % 2 == 1 && (^ch ^ (l == 3)), ch});
      i_serial_peer.send({^ch ^ (l == 3), ch});
      repeat (4) @(posedge clock);
      rdc(uart_pkg::OFF_DATA, 34'(ch));
      rdc(uart_pkg::OFF_IRQ_STATUS, 34'h03);
      wr(uart_pkg::OFF_IRQ_STATUS, 32'h1F);
    end
    // five back to back into a four-deep buffer
    repeat (5) begin
      ch = 8'(xs());
      if (ex.size() < 4) ex.push_back(ch);
      i_serial_peer.send({~^ch, ch});
    end
    repeat (4) @(posedge clock);
    rdc(uart_pkg::OFF_STATUS, 34'h64);
    rdc(uart_pkg::OFF_IRQ_STATUS, 34'h05);
    chk(34'(irq), 34'h1);
    while (ex.size() > 0) rdc(uart_pkg::OFF_DATA, 34'(ex.pop_front()));
    wr(uart_pkg::OFF_IRQ_STATUS, 32'h1F);
    i_serial_peer.send({^ch, ch});
    repeat (4) @(posedge clock);
    chk(34'(irq), 34'h1);
    wr(uart_pkg::OFF_IRQ_MASK, 32'h0);
    chk(34'(irq), 34'h0);
    chk(34'(rtsN), 34'h1);
    rdc(uart_pkg::OFF_DATA, 34'(ch));
    // local loopback timed by the external baud input; line must stay idle
    wr(uart_pkg::OFF_CONFIG, 32'(uart_pkg::CFG_RESET) | 32'h00000C00);
    ch = 8'(xs());
    wr(uart_pkg::OFF_DATA, 32'(ch));
    repeat (400) begin
      @(posedge clock);
      chk(34'(txd), 34'h1);
    end
    rdc(uart_pkg::OFF_DATA, 34'(ch));
    wrap_up();
  end
endmodule // tb_top
